// ### dv/pll_clock_config_assertions.sv
// concurrent checks on the ports of the clock configuration block
// assumes one clock domain, synchronous active-low reset, 1-wait-state bus
`timescale 1ns/1ns
`default_nettype none
module pll_clock_config_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// avalon-mm slave
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// status and configuration outputs
	input wire logic bus_clock_tick,
	input wire logic lock,
	input wire logic lock_irq,
	input wire logic write_guard_bit,
	input wire logic pll_source_select,
	input wire logic osc_enable,
	input wire logic osc_monitor_reset_enable,
	input wire logic osc_amplitude_mode,
	input wire logic external_transistor_enable,
	input wire logic internal_transistor_enable
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic done;
	logic [7:0] idx;
	// a write lands at the edge where waitrequest is low
	assign done = write && !waitrequest;
	assign idx = address[9:2];
	////////////////////////////////////////////////////////////////////////
	wait_pulse_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low longer than one cycle");
	bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus request not answered next cycle");
	read_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	guard_key_a: assert property (done && idx == clk_cfg_pkg::IDX_GUARD && byteenable[0]
		|=> write_guard_bit == ($past(writedata[7:0]) != clk_cfg_pkg::GUARD_KEY))
		else $error("guard bit does not follow written key");
	guard_cause_a: assert property ($changed(write_guard_bit)
		|-> $past(done && idx == clk_cfg_pkg::IDX_GUARD))
		else $error("guard bit changed without guard write");
	vreg_onehot_a: assert property (external_transistor_enable != internal_transistor_enable)
		else $error("transistor enables not exactly one");
	osc2_freeze_a: assert property ($past(osc_enable)
		|-> $stable(osc_monitor_reset_enable) && $stable(osc_amplitude_mode))
		else $error("oscillator bits changed while oscillator on");
	osc2_gate_a: assert property ($changed({osc_monitor_reset_enable, osc_amplitude_mode})
		|-> $past(done && idx == clk_cfg_pkg::IDX_OSC2 && !write_guard_bit && pll_source_select))
		else $error("oscillator bits changed without allowed write");
	bus_tick_a: assert property (bus_clock_tick |-> pll_source_select || $past(pll_source_select))
		else $error("bus tick while pll not selected");
	irq_cause_a: assert property ($rose(lock_irq) |-> $past(lock) != $past(lock, 2)
		|| $past(lock, 2) != $past(lock, 3) || $past(done) || $past(done, 2))
		else $error("lock interrupt without lock change");
	// main scenarios reached
	cover property ($rose(lock));
	cover property ($fell(lock));
	cover property ($rose(lock_irq));
	cover property (done && idx == clk_cfg_pkg::IDX_VREG);
endmodule
bind pll_clock_config_protection pll_clock_config_checker i_checker (.clk_sys, .reset_n,
	.address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .bus_clock_tick,
	.lock, .lock_irq, .write_guard_bit, .pll_source_select, .osc_enable,
	.osc_monitor_reset_enable, .osc_amplitude_mode, .external_transistor_enable,
	.internal_transistor_enable);
`default_nettype wire

// ### dv/test_pll_clock_config_protection.sv
// self-checking bench for the clock configuration block
// assumes the bound checker; reference ticks shared by both reference inputs
`timescale 1ns/1ns
`default_nettype none
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_pll_clock_config_protection;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [9:0] address = 10'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'h1;
	logic special_mode = 1'b0;
	logic ref_tick = 1'b0;
	logic ref_run = 1'b1;
	logic [7:0] ref_cnt = 8'h0;
	logic [7:0] rdata;
	logic [31:0] readdata;
	logic waitrequest, pll_output_clock, bus_clock_tick, lock, lock_irq, write_guard_bit;
	logic pll_source_select, osc_enable, osc_monitor_reset_enable, osc_amplitude_mode;
	logic external_transistor_enable, internal_transistor_enable;
	logic [1:0] reference_range, vco_range;
	int num_errors = 0;
	int checked = 0;
	pll_clock_config_protection i_dut (.clk_sys, .reset_n, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .special_mode,
		.internal_1mhz_source(ref_tick), .external_osc_clock(ref_tick), .pll_output_clock,
		.bus_clock_tick, .lock, .lock_irq, .write_guard_bit, .pll_source_select, .osc_enable,
		.osc_monitor_reset_enable, .osc_amplitude_mode, .external_transistor_enable,
		.internal_transistor_enable, .reference_range, .vco_range);
	////////////////////////////////////////////////////////////////////////
	always #2 clk_sys = ~clk_sys;
	// 1 MHz reference, one tick every 250 cycles; ref_run stops it
	always @(posedge clk_sys) begin
		ref_cnt <= (ref_cnt == 8'hf9) ? 8'h0 : ref_cnt + 8'h1;
		ref_tick <= ref_run && ref_cnt == 8'hf9;
	end
	task automatic end_sim();
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one avalon transfer: held until waitrequest is seen low at a rising
	// edge, released there; returns one edge later so effects have settled
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_sys);
		address <= {idx, 2'h0};
		writedata <= {24'h0, d};
		write <= wr;
		read <= !wr;
		do begin
			@(posedge clk_sys);
		end while (waitrequest !== 1'b0);
		rdata = readdata[7:0];
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h0);
		`CHECK(rdata, exp);
	endtask
	task automatic wait_lock(input logic v, input int limit);
		int n = 0;
		while (lock !== v && n < limit) begin
			@(negedge clk_sys);
			n++;
		end
		`CHECK(lock, v);
	endtask
	// cycles spanned by a number of pll ticks, and bus ticks inside them
	task automatic measure(input int ticks, output int cyc, output int buses);
		int seen = 0;
		cyc = 0;
		buses = 0;
		while (pll_output_clock !== 1'b1 && cyc < 200) begin
			@(negedge clk_sys);
			cyc++;
		end
		cyc = 0;
		while (seen < ticks && cyc < 4000) begin
			@(negedge clk_sys);
			cyc++;
			buses += (bus_clock_tick === 1'b1);
			seen += (pll_output_clock === 1'b1);
		end
	endtask
	function automatic logic near(input int a, input int b);
		return (a - b <= 4) && (b - a <= 4);
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk(clk_cfg_pkg::IDX_GUARD, 8'h00);
		chk(clk_cfg_pkg::IDX_SYNTH, 8'h58);
		chk(clk_cfg_pkg::IDX_POST_DIVIDER, 8'h03);
		chk(clk_cfg_pkg::IDX_REFERENCE_DIVIDER, 8'h00);
		chk(clk_cfg_pkg::IDX_CLK_SEL, 8'h80);
		chk(clk_cfg_pkg::IDX_OSC2, 8'h00);
		chk(clk_cfg_pkg::IDX_VREG, 8'h01);
		chk(clk_cfg_pkg::IDX_TEST, 8'h00);
		wr(8'h30, 8'hff);
		chk(8'h30, 8'h00);
	endtask
	task automatic t_pll();
		int c_unl, c_lk, c3, b;
		// ranges for a 1 MHz reference and a 50 MHz vco
		wr(clk_cfg_pkg::IDX_SYNTH, 8'h58);
		wr(clk_cfg_pkg::IDX_REFERENCE_DIVIDER, 8'h00);
		`CHECK({reference_range, vco_range}, 4'h1);
		wr(clk_cfg_pkg::IDX_POST_DIVIDER, 8'h00);
		`CHECK(lock, 1'b0);
		measure(4, c_unl, b);
		wait_lock(1'b1, 20000);
		`CHECK(lock_irq, 1'b0);
		chk(clk_cfg_pkg::IDX_LOCK_STAT, 8'h09);
		wr(clk_cfg_pkg::IDX_LOCK_STAT, 8'h01);
		chk(clk_cfg_pkg::IDX_LOCK_STAT, 8'h08);
		measure(16, c_lk, b);
		`CHECK(near(c_lk, c_unl), 1'b1);
		wr(clk_cfg_pkg::IDX_POST_DIVIDER, 8'h03);
		measure(16, c3, b);
		`CHECK(near(c3, 4 * c_unl), 1'b1);
		// 12.5 MHz against a 250 MHz clock is 20 cycles per tick
		`CHECK(near(c3, 16 * 20), 1'b1);
		`CHECK(b, 8);
		wr(clk_cfg_pkg::IDX_LOCK_CTRL, 8'h01);
		ref_run <= 1'b0;
		wait_lock(1'b0, 3000);
		repeat (3) @(negedge clk_sys);
		`CHECK(lock_irq, 1'b1);
		wr(clk_cfg_pkg::IDX_LOCK_STAT, 8'h01);
		// the request line follows the cleared flag one cycle later
		@(posedge clk_sys);
		`CHECK(lock_irq, 1'b0);
		ref_run <= 1'b1;
	endtask
	task automatic t_guard();
		wr(clk_cfg_pkg::IDX_GUARD, 8'h55);
		`CHECK(write_guard_bit, 1'b1);
		wr(clk_cfg_pkg::IDX_SYNTH, 8'h05);
		chk(clk_cfg_pkg::IDX_SYNTH, 8'h58);
		wr(clk_cfg_pkg::IDX_POST_DIVIDER, 8'h1f);
		chk(clk_cfg_pkg::IDX_POST_DIVIDER, 8'h03);
		wr(clk_cfg_pkg::IDX_CLK_SEL, 8'h00);
		`CHECK(pll_source_select, 1'b1);
		wr(clk_cfg_pkg::IDX_GUARD, 8'h26);
		chk(clk_cfg_pkg::IDX_GUARD, 8'h00);
		wr(clk_cfg_pkg::IDX_POST_DIVIDER, 8'h1f);
		chk(clk_cfg_pkg::IDX_POST_DIVIDER, 8'h1f);
		wr(clk_cfg_pkg::IDX_GUARD, 8'h27);
		chk(clk_cfg_pkg::IDX_GUARD, 8'h01);
		wr(clk_cfg_pkg::IDX_GUARD, 8'h26);
	endtask
	task automatic t_test();
		wr(clk_cfg_pkg::IDX_TEST, 8'ha5);
		chk(clk_cfg_pkg::IDX_TEST, 8'h00);
		special_mode <= 1'b1;
		wr(clk_cfg_pkg::IDX_TEST, 8'ha5);
		chk(clk_cfg_pkg::IDX_TEST, 8'ha5);
		special_mode <= 1'b0;
	endtask
	task automatic t_vreg();
		wr(clk_cfg_pkg::IDX_VREG, 8'h03);
		chk(clk_cfg_pkg::IDX_VREG, 8'h01);
		wr(clk_cfg_pkg::IDX_VREG, 8'h00);
		chk(clk_cfg_pkg::IDX_VREG, 8'h01);
		wr(clk_cfg_pkg::IDX_VREG, 8'h02);
		`CHECK({external_transistor_enable, internal_transistor_enable}, 2'h2);
		wr(clk_cfg_pkg::IDX_VREG, 8'h01);
		chk(clk_cfg_pkg::IDX_VREG, 8'h02);
		special_mode <= 1'b1;
		wr(clk_cfg_pkg::IDX_VREG, 8'h01);
		chk(clk_cfg_pkg::IDX_VREG, 8'h01);
		wr(clk_cfg_pkg::IDX_VREG, 8'h02);
		chk(clk_cfg_pkg::IDX_VREG, 8'h02);
		special_mode <= 1'b0;
	endtask
	task automatic t_osc2();
		wr(clk_cfg_pkg::IDX_GUARD, 8'h00);
		wr(clk_cfg_pkg::IDX_OSC2, 8'h03);
		chk(clk_cfg_pkg::IDX_OSC2, 8'h00);
		wr(clk_cfg_pkg::IDX_GUARD, 8'h26);
		wr(clk_cfg_pkg::IDX_CLK_SEL, 8'h00);
		`CHECK(pll_source_select, 1'b0);
		wr(clk_cfg_pkg::IDX_OSC2, 8'h03);
		chk(clk_cfg_pkg::IDX_OSC2, 8'h00);
		wr(clk_cfg_pkg::IDX_CLK_SEL, 8'h80);
		wr(clk_cfg_pkg::IDX_OSC2, 8'h03);
		`CHECK({osc_monitor_reset_enable, osc_amplitude_mode}, 2'h3);
		wr(clk_cfg_pkg::IDX_OSC, 8'h80);
		`CHECK(osc_enable, 1'b1);
		wr(clk_cfg_pkg::IDX_OSC2, 8'h00);
		chk(clk_cfg_pkg::IDX_OSC2, 8'h03);
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog: 50000 cycles, far above the few thousand a clean run needs
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_pll();
		t_guard();
		t_test();
		t_vreg();
		t_osc2();
		end_sim();
	end
endmodule
`default_nettype wire

// ### rtl/clk_cfg_pkg.sv
// register map, field layout, reset values and timing counts for the
// clock configuration and protection block
// assumes a 32-bit avalon-mm bus, each register in the low byte of a word
package clk_cfg_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_SYNTH = 8'h04;
	localparam logic [7:0] IDX_REFERENCE_DIVIDER = 8'h05;
	localparam logic [7:0] IDX_POST_DIVIDER = 8'h06;
	localparam logic [7:0] IDX_LOCK_STAT = 8'h07;
	localparam logic [7:0] IDX_LOCK_CTRL = 8'h08;
	localparam logic [7:0] IDX_CLK_SEL = 8'h09;
	localparam logic [7:0] IDX_OSC = 8'h1a;
	localparam logic [7:0] IDX_GUARD = 8'h1b;
	localparam logic [7:0] IDX_TEST = 8'h1c;
	localparam logic [7:0] IDX_VREG = 8'h1d;
	localparam logic [7:0] IDX_OSC2 = 8'h1e;

	// unlock key for the write guard
	localparam logic [7:0] GUARD_KEY = 8'h26;

	// field positions
	localparam int SYN_LSB = 0; // synthesizer_multiplier [5:0]
	localparam int VCO_RANGE_LSB = 6; // vco_range [7:6]
	localparam int REF_LSB = 0; // reference_divider [3:0]
	localparam int REF_RANGE_LSB = 6; // reference_range [7:6]
	localparam int POST_LSB = 0; // post_divider [4:0]
	localparam int LOCK_BIT = 3;
	localparam int LOCK_CHG_BIT = 0;
	localparam int LOCK_IE_BIT = 0;
	localparam int PLL_SEL_BIT = 7;
	localparam int OSC_EN_BIT = 7;
	localparam int EXT_TX_BIT = 1;
	localparam int INT_TX_BIT = 0;
	localparam int OSC_MONITOR_RESET_ENABLE_BIT = 1;
	localparam int OSC_MODE_BIT = 0;

	// reset values
	localparam logic [5:0] SYN_RESET = 6'h18;
	localparam logic [1:0] VCO_RANGE_RESET = 2'h1;
	localparam logic [3:0] REF_RESET = 4'h0;
	localparam logic [1:0] REF_RANGE_RESET = 2'h0;
	localparam logic [4:0] POST_RESET = 5'h03;
	localparam logic [1:0] VREG_RESET = 2'h1;
	localparam logic [7:0] TEST_RESET = 8'h00;

	// timing: clock rate and digital vco model
	localparam int CLK_MHZ = 250;
	localparam int VCO_RESET_MHZ = 50;
	localparam logic [15:0] VCO_PERIOD_RESET = 16'(CLK_MHZ / VCO_RESET_MHZ);
	localparam logic [15:0] VCO_PERIOD_MIN = 16'h0002;
	localparam logic [15:0] VCO_PERIOD_MAX = 16'hfff0;
	// reference lost after this long with no reference tick (4us at 250MHz -> 1000)
	localparam int REF_LOSS_US = 4;
	localparam logic [11:0] REF_LOSS_CYC = 12'(REF_LOSS_US * CLK_MHZ);
	// feedback ticks per reference period when on frequency
	localparam logic [7:0] FB_TARGET = 8'h02;
	// consecutive matching periods before lock sets
	localparam logic [2:0] LOCK_CONFIRM = 3'h4;
	// ratio minus one that the unlocked output divider uses
	localparam logic [4:0] UNLOCKED_DIV_M1 = 5'h03;
	localparam logic [4:0] BUS_DIV_M1 = 5'h01;
endpackage

// ### rtl/pll_clock_config_protection.sv
// clock configuration, write protection and pll model of the clock unit
// assumes avalon-mm master on clk_sys and reference ticks synchronous
// to clk_sys; clocks of the pll are modelled as one-cycle tick pulses
//
// What this block does
// - key 0x26 clears guard, other writes set
// - guard set protects all clock configuration registers
// - test register readable, writable in special mode
// - regulator register write-once unless special mode
// - regulator write needs exactly one enable bit
// - bit1 external transistor, bit0 internal transistor
// - osc2 writes need guard clear, pll selected
// - monitor reset bit frozen while oscillator enabled
// - amplitude mode bit frozen while oscillator enabled
// - reference is rc clock or divided oscillator
// - vco equals two times reference times (multiplier plus one)
// - locked output is vco over (post divider plus one)
// - unlocked output is vco over four
// - bus clock is half the pll output while pll selected
// - lock detector compares feedback against reference
// - read-only lock flag with set/clear tolerance
// - lock flag change raises interrupt when enabled
// - lost reference drops lock, vco runs slow
// - reset defaults give 50 MHz vco, divider three
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pll_clock_config_protection (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// avalon-mm slave
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// device mode and reference ticks
	input wire logic special_mode,
	input wire logic internal_1mhz_source,
	input wire logic external_osc_clock,
	// clock outputs as tick pulses
	output logic pll_output_clock,
	output logic bus_clock_tick,
	// status and configuration outputs
	output logic lock,
	output logic lock_irq,
	output logic write_guard_bit,
	output logic pll_source_select,
	output logic osc_enable,
	output logic osc_monitor_reset_enable,
	output logic osc_amplitude_mode,
	output logic external_transistor_enable,
	output logic internal_transistor_enable,
	output logic [1:0] reference_range,
	output logic [1:0] vco_range
);
	////////////////////////////////////////////////////////////////
	// bus decode
	logic [7:0] idx, wbyte, test_q, rd_d;
	logic [5:0] syn_q;
	logic [4:0] post_q;
	logic [3:0] reference_divider_q;
	logic wr_fire, lock_chg_q, lock_ie_q, vreg_written_q;

	assign idx = address[9:2];
	assign wbyte = writedata[7:0];
	// a write lands on the edge where waitrequest is seen low
	assign wr_fire = write && !waitrequest && byteenable[0];
	// true when software writes register i this cycle
	function automatic logic hit(input logic [7:0] i);
		hit = wr_fire && (idx == i);
	endfunction
	// guarded registers accept writes only with the guard clear
	function automatic logic guarded_hit(input logic [7:0] i);
		guarded_hit = hit(i) && !write_guard_bit;
	endfunction

	////////////////////////////////////////////////////////////////
	// one wait state, then the answer; unmapped reads return zero
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
			readdata <= {24'h00_0000, rd_d};
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// read mux; no read has a side effect
	always_comb begin
		rd_d = 8'h00;
		case (idx)
			clk_cfg_pkg::IDX_SYNTH: rd_d = {vco_range, syn_q};
			clk_cfg_pkg::IDX_REFERENCE_DIVIDER: rd_d = {reference_range, 2'h0, reference_divider_q};
			clk_cfg_pkg::IDX_POST_DIVIDER: rd_d = {3'h0, post_q};
			clk_cfg_pkg::IDX_LOCK_STAT: rd_d = {4'h0, lock, 2'h0, lock_chg_q};
			clk_cfg_pkg::IDX_LOCK_CTRL: rd_d = {7'h00, lock_ie_q};
			clk_cfg_pkg::IDX_CLK_SEL: rd_d = {pll_source_select, 7'h00};
			clk_cfg_pkg::IDX_OSC: rd_d = {osc_enable, 7'h00};
			clk_cfg_pkg::IDX_GUARD: rd_d = {7'h00, write_guard_bit};
			clk_cfg_pkg::IDX_TEST: rd_d = test_q;
			clk_cfg_pkg::IDX_VREG: begin
				rd_d = {6'h00, external_transistor_enable, internal_transistor_enable};
			end
			clk_cfg_pkg::IDX_OSC2: rd_d = {6'h00, osc_monitor_reset_enable, osc_amplitude_mode};
			default: rd_d = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// write guard: any write locks except the key
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			write_guard_bit <= 1'b0;
		end else if (hit(clk_cfg_pkg::IDX_GUARD)) begin
			write_guard_bit <= (wbyte != clk_cfg_pkg::GUARD_KEY);
		end
	end
	// divider chain settings, all behind the guard
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			syn_q <= clk_cfg_pkg::SYN_RESET;
			vco_range <= clk_cfg_pkg::VCO_RANGE_RESET;
			reference_divider_q <= clk_cfg_pkg::REF_RESET;
			reference_range <= clk_cfg_pkg::REF_RANGE_RESET;
			post_q <= clk_cfg_pkg::POST_RESET;
		end else begin
			if (guarded_hit(clk_cfg_pkg::IDX_SYNTH)) begin
				syn_q <= wbyte[clk_cfg_pkg::SYN_LSB +: 6];
				vco_range <= wbyte[clk_cfg_pkg::VCO_RANGE_LSB +: 2];
			end
			if (guarded_hit(clk_cfg_pkg::IDX_REFERENCE_DIVIDER)) begin
				reference_divider_q <= wbyte[clk_cfg_pkg::REF_LSB +: 4];
				reference_range <= wbyte[clk_cfg_pkg::REF_RANGE_LSB +: 2];
			end
			if (guarded_hit(clk_cfg_pkg::IDX_POST_DIVIDER)) begin
				post_q <= wbyte[clk_cfg_pkg::POST_LSB +: 5];
			end
		end
	end
	// clock select and oscillator enable, also guarded
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pll_source_select <= 1'b1;
			osc_enable <= 1'b0;
		end else begin
			if (guarded_hit(clk_cfg_pkg::IDX_CLK_SEL)) begin
				pll_source_select <= wbyte[clk_cfg_pkg::PLL_SEL_BIT];
			end
			if (guarded_hit(clk_cfg_pkg::IDX_OSC) && pll_source_select) begin
				osc_enable <= wbyte[clk_cfg_pkg::OSC_EN_BIT];
			end
		end
	end
	// second oscillator register; each bit frozen while osc runs
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			osc_monitor_reset_enable <= 1'b0;
			osc_amplitude_mode <= 1'b0;
		end else if (guarded_hit(clk_cfg_pkg::IDX_OSC2) && pll_source_select) begin
			if (!osc_enable) begin
				osc_monitor_reset_enable <= wbyte[clk_cfg_pkg::OSC_MONITOR_RESET_ENABLE_BIT];
				osc_amplitude_mode <= wbyte[clk_cfg_pkg::OSC_MODE_BIT];
			end
		end
	end
	// factory test register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			test_q <= clk_cfg_pkg::TEST_RESET;
		end else if (hit(clk_cfg_pkg::IDX_TEST) && special_mode) begin
			test_q <= wbyte;
		end
	end

	////////////////////////////////////////////////////////////////
	// regulator select: write-once in normal mode, one-hot only;
	// a blocked one-hot violation does not use up the single write
	logic vreg_legal;
	assign vreg_legal = wbyte[clk_cfg_pkg::EXT_TX_BIT] ^ wbyte[clk_cfg_pkg::INT_TX_BIT];
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			external_transistor_enable <= clk_cfg_pkg::VREG_RESET[1];
			internal_transistor_enable <= clk_cfg_pkg::VREG_RESET[0];
			vreg_written_q <= 1'b0;
		end else if (hit(clk_cfg_pkg::IDX_VREG) && vreg_legal
				&& (special_mode || !vreg_written_q)) begin
			external_transistor_enable <= wbyte[clk_cfg_pkg::EXT_TX_BIT];
			internal_transistor_enable <= wbyte[clk_cfg_pkg::INT_TX_BIT];
			vreg_written_q <= vreg_written_q | !special_mode;
		end
	end

	////////////////////////////////////////////////////////////////
	// reference selection and divider
	logic osc_ref_tick, ref_tick;
	tick_divider u_ref_div (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tick_in(external_osc_clock),
		.ratio_m1({2'h0, reference_divider_q}),
		.tick_out(osc_ref_tick)
	);
	assign ref_tick = osc_enable ? osc_ref_tick : internal_1mhz_source;

	////////////////////////////////////////////////////////////////
	// digital vco: one tick every vco_period_q cycles is one vco clock
	// period; the loop holds two feedback ticks per reference period
	logic [15:0] vco_period_q, vco_cnt_q, slow_period;
	logic [7:0] fb_cnt_q;
	logic [11:0] ref_age_q;
	logic vco_tick_q, fb_tick, ref_lost;
	// idle period of the free-running vco per range setting
	always_comb begin
		case (vco_range)
			2'h0: slow_period = clk_cfg_pkg::VCO_PERIOD_MAX;
			2'h1: slow_period = 16'h8000;
			2'h2: slow_period = 16'h4000;
			default: slow_period = 16'h2000;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			vco_cnt_q <= 16'h0000;
			vco_tick_q <= 1'b0;
		end else if (vco_cnt_q + 16'h0001 >= vco_period_q) begin
			vco_cnt_q <= 16'h0000;
			vco_tick_q <= 1'b1;
		end else begin
			vco_cnt_q <= vco_cnt_q + 16'h0001;
			vco_tick_q <= 1'b0;
		end
	end
	// feedback clock is vco over the multiplier setting plus one
	tick_divider u_fb_div (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tick_in(vco_tick_q),
		.ratio_m1(syn_q),
		.tick_out(fb_tick)
	);
	// reference watchdog; long silence counts as lost reference
	assign ref_lost = (ref_age_q == clk_cfg_pkg::REF_LOSS_CYC);
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ref_age_q <= 12'h000;
		end else if (ref_tick) begin
			ref_age_q <= 12'h000;
		end else if (!ref_lost) begin
			ref_age_q <= ref_age_q + 12'h001;
		end
	end
	// loop: per reference period steer vco so feedback hits target
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			vco_period_q <= clk_cfg_pkg::VCO_PERIOD_RESET;
			fb_cnt_q <= 8'h00;
		end else if (ref_lost) begin
			vco_period_q <= slow_period;
			fb_cnt_q <= 8'h00;
		end else if (ref_tick) begin
			fb_cnt_q <= {7'h00, fb_tick};
			if (fb_cnt_q > clk_cfg_pkg::FB_TARGET
					&& vco_period_q < clk_cfg_pkg::VCO_PERIOD_MAX) begin
				vco_period_q <= vco_period_q + 16'h0001;
			end else if (fb_cnt_q < clk_cfg_pkg::FB_TARGET
					&& vco_period_q > clk_cfg_pkg::VCO_PERIOD_MIN) begin
				vco_period_q <= vco_period_q - 16'h0001;
			end
		end else if (fb_tick && fb_cnt_q != 8'hff) begin
			fb_cnt_q <= fb_cnt_q + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// lock detector: exact match sets after a run, a miss of more
	// than one tick clears; the wider window gives hysteresis
	logic [2:0] match_q;
	logic fb_near;
	assign fb_near = (fb_cnt_q + 8'h01 >= clk_cfg_pkg::FB_TARGET)
		&& (fb_cnt_q <= clk_cfg_pkg::FB_TARGET + 8'h01);
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			lock <= 1'b0;
			match_q <= 3'h0;
		end else if (ref_lost) begin
			lock <= 1'b0;
			match_q <= 3'h0;
		end else if (ref_tick) begin
			if (fb_cnt_q == clk_cfg_pkg::FB_TARGET) begin
				if (match_q + 3'h1 >= clk_cfg_pkg::LOCK_CONFIRM) begin
					lock <= 1'b1;
				end else begin
					match_q <= match_q + 3'h1;
				end
			end else begin
				match_q <= 3'h0;
				if (!fb_near) begin
					lock <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// lock change flag, write one to clear; a change wins the clear
	logic lock_prev_q;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			lock_prev_q <= 1'b0;
			lock_chg_q <= 1'b0;
			lock_ie_q <= 1'b0;
			lock_irq <= 1'b0;
		end else begin
			lock_prev_q <= lock;
			if (lock != lock_prev_q) begin
				lock_chg_q <= 1'b1;
			end else if (hit(clk_cfg_pkg::IDX_LOCK_STAT) && wbyte[clk_cfg_pkg::LOCK_CHG_BIT]) begin
				lock_chg_q <= 1'b0;
			end
			if (hit(clk_cfg_pkg::IDX_LOCK_CTRL)) begin
				lock_ie_q <= wbyte[clk_cfg_pkg::LOCK_IE_BIT];
			end
			lock_irq <= lock_chg_q && lock_ie_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// post divider and bus divider; the vco tick stream is the vco
	// clock itself, so it enters the post divider undivided
	logic [4:0] post_m1;
	logic pll_tick;
	logic bus_tick;
	assign post_m1 = lock ? post_q : clk_cfg_pkg::UNLOCKED_DIV_M1;
	tick_divider u_post_div (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tick_in(vco_tick_q),
		.ratio_m1({1'b0, post_m1}),
		.tick_out(pll_tick)
	);
	tick_divider u_bus_div (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tick_in(pll_tick),
		.ratio_m1({1'b0, clk_cfg_pkg::BUS_DIV_M1}),
		.tick_out(bus_tick)
	);
	// register the clock ticks so outputs leave from flops
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pll_output_clock <= 1'b0;
			bus_clock_tick <= 1'b0;
		end else begin
			pll_output_clock <= pll_tick;
			bus_clock_tick <= bus_tick && pll_source_select;
		end
	end
endmodule
`default_nettype wire

// ### rtl/tick_divider.sv
// divides a one-cycle enable pulse by a programmable ratio
// assumes tick_in is synchronous to clk and at most one cycle wide
`timescale 1ns/1ns
`default_nettype none
module tick_divider (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// tick in, ratio minus one, tick out
	input wire logic tick_in,
	input wire logic [5:0] ratio_m1,
	output logic tick_out
);
	logic [5:0] cnt_q;

	////////////////////////////////////////////////////////////////
	// count input ticks; a ratio change applies from the next input tick
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_q <= 6'h00;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				if (cnt_q >= ratio_m1) begin
					cnt_q <= 6'h00;
					tick_out <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 6'h01;
				end
			end
		end
	end
endmodule
`default_nettype wire
